// file: rtl/epiu_defines.svh
`ifndef EPIU_DEFINES_SVH
`define EPIU_DEFINES_SVH

// Register byte offsets on the APB slave
`define EPIU_OFF_CORE_CONTROL 12'h000
`define EPIU_OFF_CORE_CONTROL_STATUS 12'h004
`define EPIU_OFF_PIN_IRQ_ENABLE 12'h008
`define EPIU_OFF_PIN_IRQ_FLAGS 12'h00c

// Field positions, core_control
`define EPIU_BIT_SENSE_B_HI 3
`define EPIU_BIT_SENSE_B_LO 2
`define EPIU_BIT_SENSE_A_HI 1
`define EPIU_BIT_SENSE_A_LO 0

// Field positions, core_control_status
`define EPIU_BIT_SENSE_C_POLARITY 6

// Field positions, pin_irq_enable
`define EPIU_BIT_EN_B 7
`define EPIU_BIT_EN_A 6
`define EPIU_BIT_EN_C 5

// Field positions, pin_irq_flags
`define EPIU_BIT_PENDING_B 7
`define EPIU_BIT_PENDING_A 6
`define EPIU_BIT_PENDING_C 5

// Reset values
`define EPIU_RST_CORE_CONTROL 8'h00
`define EPIU_RST_CORE_CONTROL_STATUS 8'h00
`define EPIU_RST_PIN_IRQ_ENABLE 8'h00
`define EPIU_RST_PIN_IRQ_FLAGS 8'h00

`endif

// file: rtl/epiu_pkg.sv
package epiu_pkg;

  // Sense encoding follows the two-bit field value in order 00..11
  typedef enum logic [1:0] {
    EPIU_SENSE_LOW,
    EPIU_SENSE_ANY,
    EPIU_SENSE_FALL,
    EPIU_SENSE_RISE
  } epiu_sense_e;

  // One bit per source, ordered as in the enable and flag registers
  typedef struct packed {
    logic pin_b;
    logic pin_a;
    logic pin_c;
  } epiu_src_s;

  typedef logic [7:0] epiu_byte_t;

endpackage

// file: rtl/epiu_pin_sense.sv
`timescale 1ns/1ps
module epiu_pin_sense (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire epiu_pkg::epiu_sense_e sense,
  output logic event_pulse,
  output logic level_low
);
  import epiu_pkg::*;

  logic meta_reg;
  logic stable_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  // Two stages before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      stable_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      stable_reg <= meta_reg;
      prev_reg <= stable_reg;
    end
  end

  // Edges compare sampled values only, so glitches under a period may be missed
  assign rise = stable_reg & ~prev_reg;
  assign fall = ~stable_reg & prev_reg;
  assign level_low = ~stable_reg;

  always_comb begin
    unique case (sense)
      EPIU_SENSE_LOW: event_pulse = 1'b0;
      EPIU_SENSE_ANY: event_pulse = rise | fall;
      EPIU_SENSE_FALL: event_pulse = fall;
      EPIU_SENSE_RISE: event_pulse = rise;
    endcase
  end

endmodule

// file: rtl/epiu_async_edge.sv
`timescale 1ns/1ps
module epiu_async_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic polarity_rise,
  output logic event_pulse
);

  logic edge_clk;
  logic toggle_reg;
  logic meta_reg;
  logic stable_reg;
  logic seen_reg;

  // Chosen edge becomes a rising edge; flipping polarity can itself make one
  assign edge_clk = ~(pin ^ polarity_rise);

  // Caught without pclk, so it works while the I/O clock is stopped
  always_ff @(posedge edge_clk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // Toggle crossing into pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      stable_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      meta_reg <= toggle_reg;
      stable_reg <= meta_reg;
      seen_reg <= stable_reg;
    end
  end

  assign event_pulse = stable_reg ^ seen_reg;

endmodule

// file: rtl/epiu_top.sv
`timescale 1ns/1ps
`include "epiu_defines.svh"
// Contract
// - Pin b sense: low, change, fall, rise
// - Pin a sense: same four-way encoding
// - Sample pins a, b before edge detect
// - Pin c polarity bit: fall or rise
// - Pin c edges caught without the clock
// - Enable and global bit gate each request
// - Pins trigger even when driven as outputs
// - Each source has its own vector
// - Trigger sets pending flag bits 7,6,5
// - Flag clears on vector or written one
// - Level mode keeps flag reading zero
// - Sleep buffer shutdown may set pin c flag
// - Level request holds while pin low
module epiu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic ext_irq_pin_c,
  input wire logic processor_status_ie,
  input wire logic sleep_inbuf_off,
  input wire epiu_pkg::epiu_src_s vector_ack,
  output epiu_pkg::epiu_src_s irq_req
);
  import epiu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wires

  epiu_byte_t core_control_reg;
  logic sense_c_polarity_reg;
  epiu_src_s enable_reg;
  epiu_src_s pending_reg;
  epiu_src_s pending_next;
  epiu_src_s irq_req_reg;
  epiu_src_s irq_req_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;

  epiu_sense_e sense_a;
  epiu_sense_e sense_b;
  epiu_src_s trig;
  epiu_src_s low;
  epiu_src_s level_mode;
  epiu_src_s w1c;
  logic pin_c_gated;
  logic setup_phase;
  logic access_done;
  logic wr_access;
  logic addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // APB phase decode

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_access = access_done & pwrite;

  always_comb begin
    unique case (paddr)
      `EPIU_OFF_CORE_CONTROL: addr_hit = 1'b1;
      `EPIU_OFF_CORE_CONTROL_STATUS: addr_hit = 1'b1;
      `EPIU_OFF_PIN_IRQ_ENABLE: addr_hit = 1'b1;
      `EPIU_OFF_PIN_IRQ_FLAGS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Answer comes in the first access cycle; no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  assign pslverr_next = setup_phase & ~addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle

  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (paddr)
      `EPIU_OFF_CORE_CONTROL: begin
        prdata_next[7:0] = core_control_reg;
      end
      `EPIU_OFF_CORE_CONTROL_STATUS: begin
        prdata_next[`EPIU_BIT_SENSE_C_POLARITY] = sense_c_polarity_reg;
      end
      `EPIU_OFF_PIN_IRQ_ENABLE: begin
        prdata_next[`EPIU_BIT_EN_B] = enable_reg.pin_b;
        prdata_next[`EPIU_BIT_EN_A] = enable_reg.pin_a;
        prdata_next[`EPIU_BIT_EN_C] = enable_reg.pin_c;
      end
      `EPIU_OFF_PIN_IRQ_FLAGS: begin
        prdata_next[`EPIU_BIT_PENDING_B] = pending_reg.pin_b;
        prdata_next[`EPIU_BIT_PENDING_A] = pending_reg.pin_a;
        prdata_next[`EPIU_BIT_PENDING_C] = pending_reg.pin_c;
      end
      default: begin
        prdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase) begin
      // Writes show zero, so a refused write never echoes an older read
      prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Bits 7:4 are kept for the sleep controller; this block only stores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_control_reg <= `EPIU_RST_CORE_CONTROL;
    end else if (wr_access && paddr == `EPIU_OFF_CORE_CONTROL) begin
      core_control_reg <= pwdata[7:0];
    end
  end

  // Other status bits belong to the reset logic and read as zero here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_c_polarity_reg <= 1'b0;
    end else if (wr_access && paddr == `EPIU_OFF_CORE_CONTROL_STATUS) begin
      sense_c_polarity_reg <= pwdata[`EPIU_BIT_SENSE_C_POLARITY];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= '0;
    end else if (wr_access && paddr == `EPIU_OFF_PIN_IRQ_ENABLE) begin
      enable_reg.pin_b <= pwdata[`EPIU_BIT_EN_B];
      enable_reg.pin_a <= pwdata[`EPIU_BIT_EN_A];
      enable_reg.pin_c <= pwdata[`EPIU_BIT_EN_C];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sensing

  assign sense_b = epiu_sense_e'({core_control_reg[`EPIU_BIT_SENSE_B_HI],
                                  core_control_reg[`EPIU_BIT_SENSE_B_LO]});
  assign sense_a = epiu_sense_e'({core_control_reg[`EPIU_BIT_SENSE_A_HI],
                                  core_control_reg[`EPIU_BIT_SENSE_A_LO]});

  // Pads are read regardless of pin direction, so software can raise requests
  epiu_pin_sense u_sense_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_pin_a),
    .sense(sense_a),
    .event_pulse(trig.pin_a),
    .level_low(low.pin_a)
  );

  epiu_pin_sense u_sense_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_pin_b),
    .sense(sense_b),
    .event_pulse(trig.pin_b),
    .level_low(low.pin_b)
  );

  // Disabled pin c in sleep loses its input buffer; the forced low may look like an edge
  assign pin_c_gated = ext_irq_pin_c & ~(sleep_inbuf_off & ~enable_reg.pin_c);

  // A polarity change can fire here, which is why software should mask first
  epiu_async_edge u_edge_c (
    .pclk(pclk),
    .presetn(presetn),
    .pin(pin_c_gated),
    .polarity_rise(sense_c_polarity_reg),
    .event_pulse(trig.pin_c)
  );

  assign low.pin_c = 1'b0;

  assign level_mode.pin_b = (sense_b == EPIU_SENSE_LOW);
  assign level_mode.pin_a = (sense_a == EPIU_SENSE_LOW);
  assign level_mode.pin_c = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags

  always_comb begin
    w1c = '0;
    if (wr_access && paddr == `EPIU_OFF_PIN_IRQ_FLAGS) begin
      w1c.pin_b = pwdata[`EPIU_BIT_PENDING_B];
      w1c.pin_a = pwdata[`EPIU_BIT_PENDING_A];
      w1c.pin_c = pwdata[`EPIU_BIT_PENDING_C];
    end
  end

  // A trigger in the same cycle as a clear wins, so no event is lost
  for (genvar i = 0; i < 3; i++) begin : g_pending
    always_comb begin
      if (level_mode[i]) begin
        pending_next[i] = 1'b0;
      end else begin
        pending_next[i] = trig[i] | (pending_reg[i] & ~w1c[i] & ~vector_ack[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests, one line per vector

  // Level mode requests follow the synchronised pin, not a flag
  for (genvar i = 0; i < 3; i++) begin : g_request
    always_comb begin
      if (level_mode[i]) begin
        irq_req_next[i] = enable_reg[i] & processor_status_ie & low[i];
      end else begin
        irq_req_next[i] = enable_reg[i] & processor_status_ie & pending_next[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_reg <= '0;
    end else begin
      irq_req_reg <= irq_req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = irq_req_reg;

endmodule

// file: tb/epiu_props.sv
`timescale 1ns/1ps
module epiu_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic processor_status_ie,
  input wire epiu_pkg::epiu_src_s vector_ack,
  input wire epiu_pkg::epiu_src_s irq_req
);
  import epiu_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_decode: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("wrong error response");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read data not zero");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_ie_gate: assert property (!processor_status_ie [*2] |-> irq_req == 3'b000)
    else $error("request without global enable");
  chk_ack_clear: assert property (vector_ack.pin_c |=> !irq_req.pin_c)
    else $error("request stays after vector");
  ////////////////////////////////////////
  cover property ($rose(irq_req.pin_a));
  cover property ($rose(irq_req.pin_b));
  cover property ($rose(irq_req.pin_c));
endmodule
bind epiu_top epiu_props i_epiu_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .processor_status_ie(processor_status_ie), .vector_ack(vector_ack), .irq_req(irq_req)
);

// file: tb/epiu_pin_src.sv
`timescale 1ns/1ps
module epiu_pin_src (
  input wire logic pclk,
  input wire epiu_pkg::epiu_src_s want,
  output epiu_pkg::epiu_src_s pins
);
  import epiu_pkg::*;
  initial pins = 3'b111;
  always @(posedge pclk) begin
    pins.pin_b <= want.pin_b;
    pins.pin_a <= want.pin_a;
  end
  // Unclocked copy of want delayed 17 ns, so pin c moves off the clock edge
  always @(want.pin_c) pins.pin_c <= #17 want.pin_c;
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import epiu_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, ie, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  epiu_src_s want, pins, vack, irq_req;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #25 pclk = ~pclk;
  epiu_pin_src i_epiu_pin_src (.pclk(pclk), .want(want), .pins(pins));
  epiu_top i_epiu_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_a(pins.pin_a), .ext_irq_pin_b(pins.pin_b),
    .ext_irq_pin_c(pins.pin_c), .processor_status_ie(ie), .sleep_inbuf_off(sleep),
    .vector_ack(vack), .irq_req(irq_req));
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("TB: errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic irq(input logic [2:0] x);
    chk({29'h0, irq_req}, {29'h0, x});
  endtask
  // Idle cycle at the end, so back-to-back calls never drive psel twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk({31'h0, pslverr}, {31'h0, er});
    if (!w) chk(prdata, {24'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ie, sleep} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    want = 3'b111;
    vack = 3'b000;
    cyc(5);
    presetn <= 1'b1;
    ie <= 1'b1;
    for (int i = 0; i < 5; i++) apb(0, 12'(i * 4), 0, 0, i == 4);
    apb(1, 12'h008, 8'he0, 0, 0);
    apb(0, 12'h008, 0, 8'he0, 0);
    for (int m = 1; m < 4; m++) begin
      apb(1, 12'h000, 8'(m * 5), 0, 0);
      apb(0, 12'h000, 0, 8'(m * 5), 0);
      want <= 3'b001;
      cyc(8);
      irq(m == 3 ? 3'b000 : 3'b110);
      apb(0, 12'h00c, 0, m == 3 ? 8'h00 : 8'hc0, 0);
      want <= 3'b111;
      cyc(8);
      apb(0, 12'h00c, 0, 8'hc0, 0);
      apb(1, 12'h00c, 8'hc0, 0, 0);
    end
    apb(1, 12'h000, 8'h0a, 0, 0);
    want <= 3'b001;
    cyc(3);
    want <= 3'b111;
    cyc(6);
    irq(3'b110);
    vack <= 3'b010;
    cyc(1);
    vack <= 3'b000;
    cyc(2);
    irq(3'b100);
    ie <= 1'b0;
    cyc(3);
    irq(3'b000);
    ie <= 1'b1;
    apb(1, 12'h008, 8'h60, 0, 0);
    // The request line follows an enable write one edge later
    cyc(1);
    irq(3'b000);
    apb(1, 12'h008, 8'he0, 0, 0);
    cyc(2);
    irq(3'b100);
    apb(1, 12'h00c, 8'h00, 0, 0);
    apb(0, 12'h00c, 0, 8'h80, 0);
    apb(1, 12'h00c, 8'h80, 0, 0);
    apb(0, 12'h00c, 0, 8'h00, 0);
    apb(1, 12'h000, 8'h00, 0, 0);
    want <= 3'b101;
    cyc(6);
    irq(3'b010);
    apb(0, 12'h00c, 0, 8'h00, 0);
    cyc(20);
    irq(3'b010);
    want <= 3'b111;
    cyc(6);
    irq(3'b000);
    for (int p = 0; p < 2; p++) begin
      apb(1, 12'h008, 8'hc0, 0, 0);
      apb(1, 12'h004, 8'(p << 6), 0, 0);
      apb(0, 12'h004, 0, 8'(p << 6), 0);
      cyc(6);
      apb(1, 12'h00c, 8'h20, 0, 0);
      apb(1, 12'h008, 8'he0, 0, 0);
      want.pin_c <= p[0];
      cyc(6);
      apb(0, 12'h00c, 0, 8'h20, 0);
      irq(3'b001);
      vack <= 3'b001;
      cyc(1);
      vack <= 3'b000;
    end
    apb(1, 12'h008, 8'hc0, 0, 0);
    apb(1, 12'h004, 8'h00, 0, 0);
    cyc(6);
    apb(1, 12'h00c, 8'h20, 0, 0);
    sleep <= 1'b1;
    cyc(6);
    apb(0, 12'h00c, 0, 8'h20, 0);
    sleep <= 1'b0;
    report_and_stop();
  end
endmodule
